// *** dv/dvs_chk_assertions.sv ***
// Purpose: port checks of the ramp and linear-regulator block
// Assumes: one clock, synchronous active-low reset
// Notes: blank length is allowed one cycle of slack
module dvs_chk #(parameter BLANK_CYC = 200000) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_wdata_i,
	input wire pw_unlock_i,
	input wire buck_converter_one_update_i,
	input wire buck_converter_two_update_i,
	input wire [7:0] reg_rdata_o,
	input wire [5:0] buck_converter_one_applied_o,
	input wire ramp_busy_o,
	input wire [5:0] linear_regulator_one_code_o,
	input wire [11:0] linear_regulator_one_mv_o,
	input wire linear_regulator_one_blank_o
);
wire wa = reg_wr_i && reg_addr_i == 8'h1a;
wire wb = reg_wr_i && reg_addr_i == 8'h1b && pw_unlock_i;
wire upd = buck_converter_one_update_i || buck_converter_two_update_i;
wire bz = ramp_busy_o;
wire bl = linear_regulator_one_blank_o;
wire [5:0] ap = buck_converter_one_applied_o;
wire [11:0] c = {6'h00, linear_regulator_one_code_o};
reg [2:0] rate_q;
reg byp_q;
reg [31:0] cnt_q;
always @(posedge sys_clk_i) begin
	rate_q <= !rst_n_i ? 3'h6 : wa ? reg_wdata_i[2:0] : rate_q;
	byp_q <= !rst_n_i ? 1'b0 : wa ? reg_wdata_i[6] : byp_q;
	cnt_q <= (!rst_n_i || wb) ? 32'h0 : cnt_q + 32'h1;
end
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_n_i);
a_trig_starts: assert property (wa && reg_wdata_i[7] |=> bz) else $error("no ramp");
a_zero_idle: assert property (!bz && wa && !reg_wdata_i[7] && !upd |=> !bz) else $error("zero ramp");
a_bypass_start: assert property (upd && !wa && !bz |=> bz == byp_q) else $error("bypass");
a_step_paced: assert property ($changed(ap) && rate_q != 3'h7 |=> $stable(ap)) else $error("pace");
a_rsv_zero: assert property (reg_rd_i && reg_addr_i == 8'h1a |=> reg_rdata_o[5:3] == 3'h0) else $error("rsv");
a_locked_ignored: assert property (reg_wr_i && reg_addr_i == 8'h1b && !pw_unlock_i && !bl |=> !bl) else $error("lock");
a_code_taken: assert property (wb |-> ##2 c[5:0] == $past(reg_wdata_i[5:0], 2)) else $error("code");
a_blank_on: assert property (wb |=> bl) else $error("blank");
a_blank_len: assert property ($fell(bl) |-> cnt_q >= BLANK_CYC - 1 && cnt_q <= BLANK_CYC + 1) else $error("len");
a_mv_map: assert property (linear_regulator_one_mv_o == (c <= 12'h19 ? 12'd900 + 12'd25 * c
	: 12'd1550 + 12'd50 * (c - 12'h1a))) else $error("mv");
c_ramp: cover property ($fell(bz));
c_blank: cover property ($fell(bl));
c_byp: cover property (byp_q && upd);
endmodule // dvs_chk
bind dvs_slew_and_linreg_setpoint dvs_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (.sys_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wr_i, .reg_rd_i, .reg_wdata_i, .pw_unlock_i, .buck_converter_one_update_i, .buck_converter_two_update_i,
	.reg_rdata_o, .buck_converter_one_applied_o, .ramp_busy_o, .linear_regulator_one_code_o,
	.linear_regulator_one_mv_o, .linear_regulator_one_blank_o);

// *** dv/dvs_slew_and_linreg_setpoint_tb.sv ***
// Purpose: self-checking bench of the ramp and linear-regulator block
// Assumes: dwell shortened to 640 cycles for code 0 only; other codes keep their counts
// Notes: blanking shortened to 50 cycles
module dvs_slew_and_linreg_setpoint_tb;
timeunit 1ns;
timeprecision 1ps;
localparam BC = 50;
logic sys_clk_i = 1'b0;
logic rst_n_i = 1'b0;
logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
logic reg_wr_i, reg_rd_i, pw_unlock_i, ramp_busy_o, linear_regulator_one_blank_o;
logic buck_converter_one_update_i = 1'b0;
logic buck_converter_two_update_i = 1'b0;
logic [5:0] buck_converter_one_setpoint_i = 6'h02;
logic [5:0] buck_converter_two_setpoint_i = 6'h01;
logic [5:0] buck_converter_one_applied_o, buck_converter_two_applied_o, linear_regulator_one_code_o;
logic [11:0] linear_regulator_one_mv_o;
logic [17:0] rows [4] = '{{6'h00, 12'd900}, {6'h19, 12'd1525}, {6'h1a, 12'd1550}, {6'h3f, 12'd3400}};
int miscompares = 0;
int n_checks = 0;
always #12.5 sys_clk_i = ~sys_clk_i;
reg_host host (.clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
	.wr_o(reg_wr_i), .rd_o(reg_rd_i), .unlock_o(pw_unlock_i));
dvs_slew_and_linreg_setpoint #(.DWELL0_CYC(640), .BLANK_CYC(BC)) dut (.sys_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wr_i, .reg_rd_i, .reg_wdata_i, .pw_unlock_i, .buck_converter_one_setpoint_i,
	.buck_converter_two_setpoint_i, .buck_converter_one_update_i, .buck_converter_two_update_i, .reg_rdata_o,
	.buck_converter_one_applied_o, .buck_converter_two_applied_o, .ramp_busy_o, .linear_regulator_one_code_o,
	.linear_regulator_one_mv_o, .linear_regulator_one_blank_o);
task chk(input logic [11:0] got, input logic [11:0] exp);
	n_checks++;
	if (got !== exp) begin
		miscompares++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task print_verdict;
	$display("checks %0d mismatches %0d", n_checks, miscompares);
	if (miscompares == 0 && n_checks > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task tick(input int n);
	repeat (n) @(posedge sys_clk_i);
	#1;
endtask
// bounded wait of 3000 cycles: longer than any ramp this bench starts
task wait_busy(input logic v);
	int n;
	n = 0;
	while (ramp_busy_o !== v && n < 3000) begin
		tick(1);
		n++;
	end
	if (n == 3000) begin
		miscompares++;
		print_verdict;
	end
endtask
initial begin
	tick(6);
	rst_n_i <= 1'b1;
	host.rd(8'h1a, q);
	chk(q, 8'h06);
	host.rd(8'h1b, q);
	chk(q, 8'h1f);
	host.rd(8'h1c, q);
	chk(q, 8'h00);
	chk(linear_regulator_one_mv_o, 12'd1800);
	$display("reset done");
	foreach (rows[k]) begin
		host.wr(8'h1b, {2'h3, rows[k][17:12]}, 1'b1);
		host.rd(8'h1b, q);
		chk(q, {2'h0, rows[k][17:12]});
		chk(linear_regulator_one_blank_o, 1'b1);
		chk(linear_regulator_one_mv_o, rows[k][11:0]);
	end
	tick(BC + 2);
	chk(linear_regulator_one_blank_o, 1'b0);
	host.wr(8'h1b, 8'h05, 1'b0);
	tick(1);
	chk(linear_regulator_one_blank_o, 1'b0);
	host.rd(8'h1b, q);
	chk(q, 8'h3f);
	$display("setpoint table done");
	host.wr(8'h1a, 8'h00, 1'b0);
	tick(1);
	chk(ramp_busy_o, 1'b0);
	host.wr(8'h1a, 8'h80, 1'b0);
	wait_busy(1'b1);
	host.rd(8'h1a, q);
	chk(q, 8'h80);
	tick(600);
	chk(buck_converter_one_applied_o, 6'h00);
	wait_busy(1'b0);
	chk(buck_converter_one_applied_o, 6'h02);
	chk(buck_converter_two_applied_o, 6'h01);
	chk(linear_regulator_one_code_o, 6'h3f);
	host.rd(8'h1a, q);
	chk(q, 8'h00);
	$display("trigger ramp done");
	host.wr(8'h1a, 8'h46, 1'b0);
	@(posedge sys_clk_i);
	buck_converter_one_setpoint_i <= 6'h00;
	buck_converter_one_update_i <= 1'b1;
	@(posedge sys_clk_i);
	buck_converter_one_update_i <= 1'b0;
	wait_busy(1'b1);
	wait_busy(1'b0);
	chk(buck_converter_one_applied_o, 6'h00);
	$display("bypass done");
	buck_converter_one_setpoint_i <= 6'h05;
	host.wr(8'h1a, 8'h87, 1'b0);
	tick(2);
	chk(buck_converter_one_applied_o, 6'h05);
	wait_busy(1'b0);
	$display("immediate done");
	buck_converter_one_setpoint_i <= 6'h08;
	host.wr(8'h1a, 8'h86, 1'b0);
	tick(50);
	buck_converter_one_setpoint_i <= 6'h06;
	wait_busy(1'b0);
	chk(buck_converter_one_applied_o, 6'h06);
	$display("retarget done");
	rst_n_i <= 1'b0;
	tick(2);
	rst_n_i <= 1'b1;
	chk(ramp_busy_o, 1'b0);
	chk(buck_converter_one_applied_o, 6'h00);
	chk(linear_regulator_one_code_o, 6'h1f);
	host.rd(8'h1a, q);
	chk(q, 8'h06);
	$display("mid-run reset done");
	print_verdict;
end
endmodule // dvs_slew_and_linreg_setpoint_tb

// *** dv/reg_host.sv ***
// Purpose: host processor side of the register port
// Assumes: one-cycle strobes launched after a rising edge
// Notes: released data shows the inverse so stale values never look valid
module reg_host (
	input wire clk_i,
	input wire [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	output logic unlock_o
);
timeunit 1ns;
timeprecision 1ps;
initial begin
	{addr_o, wdata_o, wr_o, rd_o, unlock_o} = 19'h0;
end
// lowering setpoints with pulse-skip on is never requested here
task wr(input logic [7:0] a, input logic [7:0] d, input logic u);
	@(posedge clk_i);
	addr_o <= a;
	wdata_o <= d;
	unlock_o <= u;
	wr_o <= 1'b1;
	@(posedge clk_i);
	wr_o <= 1'b0;
	unlock_o <= 1'b0;
	wdata_o <= ~d;
endtask
task rd(input logic [7:0] a, output logic [7:0] q);
	@(posedge clk_i);
	addr_o <= a;
	rd_o <= 1'b1;
	@(posedge clk_i);
	rd_o <= 1'b0;
	#1 q = rdata_i;
endtask
endmodule // reg_host

// *** hw/dvs_slew_and_linreg_setpoint.v ***
// Purpose: dynamic voltage ramp control of buck one and two, linear-regulator setpoint
// Assumes: register port writes are one-cycle strobes; password check done outside
// Notes: other regulators are not touched by any logic here
`include "dvs_slew_regs.vh"

module dvs_slew_and_linreg_setpoint #(
	parameter DWELL0_CYC = `DWELL0_CYCLES,
	parameter BLANK_CYC = `BLANK_CYCLES
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_wdata_i,
	input wire pw_unlock_i,
	input wire [5:0] buck_converter_one_setpoint_i,
	input wire [5:0] buck_converter_two_setpoint_i,
	input wire buck_converter_one_update_i,
	input wire buck_converter_two_update_i,
	output reg [7:0] reg_rdata_o,
	output reg [5:0] buck_converter_one_applied_o,
	output reg [5:0] buck_converter_two_applied_o,
	output reg ramp_busy_o,
	output reg [5:0] linear_regulator_one_code_o,
	output reg [11:0] linear_regulator_one_mv_o,
	output reg linear_regulator_one_blank_o
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	function [11:0] ldo_mv;
		input [5:0] code;
		begin
			if (code <= `LDO_FINE_LAST) begin
				ldo_mv = `LDO_FINE_BASE_MV + `LDO_FINE_STEP_MV * {6'h00, code};
			end else begin
				ldo_mv = `LDO_COARSE_BASE_MV +
					`LDO_COARSE_STEP_MV * {6'h00, code - (`LDO_FINE_LAST + 6'h01)};
			end
		end
	endfunction

	// one code step toward the target, or stay
	function [5:0] step_toward;
		input [5:0] now;
		input [5:0] goal;
		begin
			if (now < goal) begin
				step_toward = now + 6'h01;
			end else if (now > goal) begin
				step_toward = now - 6'h01;
			end else begin
				step_toward = now;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register state

	reg trigger_q;
	reg trigger_bypass_q;
	reg [2:0] ramp_rate_q;
	reg [5:0] ldo_code_q;
	reg active_q;
	reg [5:0] target_one_q;
	reg [5:0] target_two_q;
	reg [17:0] blank_count_q;
	wire step_tick;

	wire wr_ramp = reg_wr_i && (reg_addr_i == `RAMP_CONTROL_OFS);
	wire wr_ldo = reg_wr_i && (reg_addr_i == `LINEAR_REG_VOLTAGE_OFS);
	wire ldo_accept = wr_ldo && pw_unlock_i;
	wire trigger_write = wr_ramp && reg_wdata_i[`TRIGGER_BIT];
	wire any_update = buck_converter_one_update_i || buck_converter_two_update_i;
	// the bypass in effect is the one stored before this cycle's write
	wire bypass_start = trigger_bypass_q && any_update;
	wire start = trigger_write || bypass_start;
	wire immediate = (ramp_rate_q == `RAMP_RATE_IMMEDIATE);
	wire at_target = (buck_converter_one_applied_o == target_one_q) &&
		(buck_converter_two_applied_o == target_two_q);
	wire done = active_q && at_target;

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			trigger_q <= 1'b0;
			trigger_bypass_q <= 1'b0;
			ramp_rate_q <= `RAMP_RATE_RESET;
			ldo_code_q <= `LDO_CODE_RESET;
		end else begin
			if (wr_ramp) begin
				// bits 5-3 are not stored, so they read back zero
				trigger_bypass_q <= reg_wdata_i[`TRIGGER_BYPASS_BIT];
				ramp_rate_q <= reg_wdata_i[`RAMP_RATE_MSB:0];
			end
			// a new trigger in the completing cycle wins over the clear
			if (trigger_write) begin
				trigger_q <= 1'b1;
			end else if (done) begin
				trigger_q <= 1'b0;
			end
			if (ldo_accept) begin
				ldo_code_q <= reg_wdata_i[`LDO_CODE_MSB:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ramp engine, buck one and two only

	ramp_step_timer #(
		.DWELL0_CYC(DWELL0_CYC)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(active_q && !immediate),
		.rate_i(ramp_rate_q),
		.tick_o(step_tick)
	);

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			active_q <= 1'b0;
			target_one_q <= `BUCK_RESET_CODE;
			target_two_q <= `BUCK_RESET_CODE;
			buck_converter_one_applied_o <= `BUCK_RESET_CODE;
			buck_converter_two_applied_o <= `BUCK_RESET_CODE;
			ramp_busy_o <= 1'b0;
		end else begin
			// while ramping the target tracks the newest setpoint
			if (start || active_q) begin
				target_one_q <= buck_converter_one_setpoint_i;
				target_two_q <= buck_converter_two_setpoint_i;
			end
			if (start) begin
				active_q <= 1'b1;
			end else if (done) begin
				active_q <= 1'b0;
			end
			if (active_q && immediate) begin
				buck_converter_one_applied_o <= target_one_q;
				buck_converter_two_applied_o <= target_two_q;
			end else if (active_q && step_tick) begin
				// one code per dwell on each converter; only bucks one and two exist here
				buck_converter_one_applied_o <= step_toward(buck_converter_one_applied_o, target_one_q);
				buck_converter_two_applied_o <= step_toward(buck_converter_two_applied_o, target_two_q);
			end
			ramp_busy_o <= start || (active_q && !done);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// linear regulator setpoint and monitor blanking

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			blank_count_q <= 18'h00000;
			linear_regulator_one_blank_o <= 1'b0;
			linear_regulator_one_code_o <= `LDO_CODE_RESET;
			linear_regulator_one_mv_o <= ldo_mv(`LDO_CODE_RESET);
		end else begin
			// a write during blanking restarts the full interval
			if (ldo_accept) begin
				blank_count_q <= BLANK_CYC[17:0];
			end else if (blank_count_q != 18'h00000) begin
				blank_count_q <= blank_count_q - 18'h00001;
			end
			linear_regulator_one_blank_o <= ldo_accept || (blank_count_q > 18'h00001);
			linear_regulator_one_code_o <= ldo_code_q;
			linear_regulator_one_mv_o <= ldo_mv(ldo_code_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`RAMP_CONTROL_OFS: reg_rdata_o <= {trigger_q, trigger_bypass_q, 3'h0, ramp_rate_q};
			`LINEAR_REG_VOLTAGE_OFS: reg_rdata_o <= {2'h0, ldo_code_q};
			default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

endmodule // dvs_slew_and_linreg_setpoint

// *** hw/dvs_slew_regs.vh ***
// Overview of operation
// - writing one to trigger bit 7 ramps both bucks to their setpoints; zero does nothing.
// - hardware clears the trigger bit when the started transition completes.
// - bypass bit 6 set: each setpoint update starts a ramp without a trigger.
// - ramp field bits 2-0, reset 6h, gives 160 down to 2.5 us per step.
// - ramp code 7h applies the new setpoint at once, no step pacing.
// - pacing, trigger and bypass act only on buck converters one and two.
// - linear-regulator setpoint accepts writes only when password unlocked.
// - any accepted linear-regulator write blanks its voltage monitoring for 5 ms.
// - six-bit setpoint: 0.900-1.525 V in 25 mV, then 1.550-3.400 V in 50 mV.
//
// Purpose: offsets, fields, reset values and timing counts of the ramp block
// Assumes: 40 MHz system clock
// Notes: dwell times are kept in ns and blanking in ms; counts derive from the clock period
`ifndef DVS_SLEW_REGS_VH
`define DVS_SLEW_REGS_VH

`define RAMP_CONTROL_OFS 8'h1a
`define LINEAR_REG_VOLTAGE_OFS 8'h1b
`define RAMP_CONTROL_RESET 8'h06
`define LINEAR_REG_VOLTAGE_RESET 8'h1f
`define TRIGGER_BIT 7
`define TRIGGER_BYPASS_BIT 6
`define RAMP_RATE_MSB 2
`define RAMP_RATE_RESET 3'h6
`define RAMP_RATE_IMMEDIATE 3'h7
`define LDO_CODE_MSB 5
`define LDO_CODE_RESET 6'h1f
`define LDO_FINE_LAST 6'h19
`define LDO_FINE_BASE_MV 12'd900
`define LDO_FINE_STEP_MV 12'd25
`define LDO_COARSE_BASE_MV 12'd1550
`define LDO_COARSE_STEP_MV 12'd50
`define BUCK_RESET_CODE 6'h00

`define CLK_PERIOD_NS 25
`define DWELL0_NS 160000
`define DWELL1_NS 80000
`define DWELL2_NS 40000
`define DWELL3_NS 20000
`define DWELL4_NS 10000
`define DWELL5_NS 5000
`define DWELL6_NS 2500
`define DWELL0_CYCLES (`DWELL0_NS / `CLK_PERIOD_NS)
`define DWELL1_CYCLES (`DWELL1_NS / `CLK_PERIOD_NS)
`define DWELL2_CYCLES (`DWELL2_NS / `CLK_PERIOD_NS)
`define DWELL3_CYCLES (`DWELL3_NS / `CLK_PERIOD_NS)
`define DWELL4_CYCLES (`DWELL4_NS / `CLK_PERIOD_NS)
`define DWELL5_CYCLES (`DWELL5_NS / `CLK_PERIOD_NS)
`define DWELL6_CYCLES (`DWELL6_NS / `CLK_PERIOD_NS)
`define BLANK_MS 5
`define BLANK_CYCLES ((`BLANK_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** hw/ramp_step_timer.v ***
// Purpose: step dwell timer for the setpoint ramp
// Assumes: run held high for the whole ramp
// Notes: tick is one cycle wide, once per dwell interval
`include "dvs_slew_regs.vh"

module ramp_step_timer #(
	parameter DWELL0_CYC = `DWELL0_CYCLES
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire run_i,
	input wire [2:0] rate_i,
	output reg tick_o
);

	reg [17:0] count_q;

	// every dwell count is held at the counter width so the compare never truncates
	localparam [17:0] DWELL1_CYC = `DWELL1_CYCLES;
	localparam [17:0] DWELL2_CYC = `DWELL2_CYCLES;
	localparam [17:0] DWELL3_CYC = `DWELL3_CYCLES;
	localparam [17:0] DWELL4_CYC = `DWELL4_CYCLES;
	localparam [17:0] DWELL5_CYC = `DWELL5_CYCLES;
	localparam [17:0] DWELL6_CYC = `DWELL6_CYCLES;

	function [17:0] dwell_of;
		input [2:0] code;
		begin
			case (code)
			3'h0: dwell_of = DWELL0_CYC[17:0];
			3'h1: dwell_of = DWELL1_CYC;
			3'h2: dwell_of = DWELL2_CYC;
			3'h3: dwell_of = DWELL3_CYC;
			3'h4: dwell_of = DWELL4_CYC;
			3'h5: dwell_of = DWELL5_CYC;
			3'h6: dwell_of = DWELL6_CYC;
			default: dwell_of = 18'h00001;
			endcase
		end
	endfunction

	// a rate change mid-ramp takes effect at once: the running count is compared against the new dwell
	always @(posedge sys_clk_i) begin
		if (!rst_n_i || !run_i) begin
			count_q <= 18'h00001;
			tick_o <= 1'b0;
		end else if (count_q >= dwell_of(rate_i)) begin
			count_q <= 18'h00001;
			tick_o <= 1'b1;
		end else begin
			count_q <= count_q + 18'h00001;
			tick_o <= 1'b0;
		end
	end

endmodule // ramp_step_timer
